// ==== src/port_r_pkg.sv ====
// Purpose: shared constants and types for the port R pin steering block
// Assumes: eight-bit register bus, one word per offset
// Notes: offsets below are the block's own register map

package port_r_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_ANA_PULL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RSVD = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_LEVELS = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_DIR = 4'h4;

    // ************************************************************
    // reset and fixed read values
    // ************************************************************
    localparam logic [DATA_W-1:0] ANA_PULL_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'h00;
    localparam logic [DATA_W-1:0] RSVD_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_RST = 8'h00;

    // ************************************************************
    // pin positions of the alternative functions
    // ************************************************************
    localparam int BIT_CAN_RX = 0;
    localparam int BIT_CAN_TX = 1;
    localparam int BIT_T1_LO = 2;
    localparam int BIT_T1_HI = 3;
    localparam int BIT_SEG_LO = 4;
    localparam int BIT_SDA = 5;
    localparam int BIT_SCL = 6;
    localparam int BIT_SEG_HI = 7;

    // who owns a pin this cycle
    typedef enum logic [2:0] {
        OWN_GPIO,
        OWN_SEG,
        OWN_SERIAL,
        OWN_TIMER,
        OWN_CAN_TX,
        OWN_CAN_RX
    } owner_t;

endpackage

// ==== src/pin_sync_if.sv ====
// Purpose: carries raw pin levels into the synchroniser and clean levels back
// Assumes: both ends on sys_clk_i
// Notes: raw side is asynchronous to the clock
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    modport sync (input raw, output lvl);
    modport owner (output raw, input lvl);
endinterface

`default_nettype wire

// ==== src/pin_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: raw pins asynchronous to sys_clk_i
// Notes: clean level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // pins in, clean levels out
    pin_sync_if.sync bus
);
    import port_r_pkg::*;

    generate
        if (W < 1) begin : g_bad_width
            $error("pin_sync width must be at least one");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_state_t;

    sync_state_t cur_ff;
    sync_state_t nxt_state;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_state = cur_ff;
        nxt_state.s1 = bus.raw;
        nxt_state.s2 = cur_ff.s1;
        nxt_state.s3 = cur_ff.s2;
        // staged sync filter
        // s1 is never looked at here, only copied on
        for (int b = 0; b < W; b++) begin
            if (cur_ff.s2[b] == cur_ff.s3[b]) begin
                nxt_state.lvl[b] = cur_ff.s3[b];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign bus.lvl = cur_ff.lvl;

endmodule

`default_nettype wire

// ==== src/port_r_gpio.sv ====
// Purpose: port R data, direction and pin level registers, pin owner priority,
//          and the analog-shared port pull enables
// Assumes: peripheral enables and outputs come from logic on sys_clk_i
// Notes: pin drive and pull outputs are registered, one cycle behind inputs
//
// Behaviour
// - each analog pull bit written 1 enables, 0 disables its pull device
// - analog pin used as output keeps its pull device off
// - analog pull direction follows the separate polarity select input
// - analog pull register is readable and writable at any time
// - reserved slots read 0x00 and drop all writes
// - unowned output pin drives the stored data bit
// - data read gives stored bit when direction is 1, else pin level
// - enabled segment drive owns bits 7 and 4
// - on bits 6 and 5 segment beats serial, serial beats general use
// - enabled second timer compare owns bits 3 and 2
// - routed and enabled CAN transmit owns bit 1 above first timer
// - routed and enabled CAN receive owns bit 0 above first timer
// - without CAN, first timer compare owns bits 1 and 0
// - pin level register always shows buffered pin levels
// - pin level read lets software spot shorted or overloaded outputs
// - writes to the pin level register are ignored
// - direction bit 1 means output, 0 means input
// - reads settle within a few cycles after a direction change
`timescale 1ns/1ps
`default_nettype none

module port_r_gpio (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [port_r_pkg::ADDR_W-1:0] addr_i,
    input wire logic [port_r_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [port_r_pkg::DATA_W-1:0] rdata_o,
    // port R pins
    input wire logic [port_r_pkg::DATA_W-1:0] pin_i,
    output logic [port_r_pkg::DATA_W-1:0] pin_o,
    output logic [port_r_pkg::DATA_W-1:0] pin_oe_o,
    output logic [port_r_pkg::DATA_W-1:0] pin_level_o,
    // segment driver, bits 7 6 5 4 in index 3 2 1 0
    input wire logic [3:0] seg_en_i,
    input wire logic [3:0] seg_val_i,
    // two-wire serial unit, open drain, high pulls the line low
    input wire logic serial_en_i,
    input wire logic scl_low_i,
    input wire logic sda_low_i,
    // second timer compare, bits 3 and 2
    input wire logic [1:0] t2_oc_en_i,
    input wire logic [1:0] t2_oc_val_i,
    // first timer compare, bits 1 and 0
    input wire logic [1:0] t1_oc_en_i,
    input wire logic [1:0] t1_oc_val_i,
    // controller area node, routed and enabled already folded in
    input wire logic can_tx_en_i,
    input wire logic can_tx_i,
    input wire logic can_rx_en_i,
    // analog-shared port, direction and polarity owned elsewhere
    input wire logic [port_r_pkg::DATA_W-1:0] ana_dir_i,
    input wire logic [port_r_pkg::DATA_W-1:0] ana_pol_i,
    output logic [port_r_pkg::DATA_W-1:0] ana_pull_en_o,
    output logic [port_r_pkg::DATA_W-1:0] ana_pull_up_o
);
    import port_r_pkg::*;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // owner map and segment indexing assume eight pins
    generate
        if (DATA_W != 8) begin : g_bad_data_w
            $error("port_r_gpio needs exactly eight pins");
        end
        // five offsets in use, so three address bits at least
        if (ADDR_W < 3) begin : g_bad_addr_w
            $error("port_r_gpio needs at least three address bits");
        end
    endgenerate

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] dir;
        logic [DATA_W-1:0] ana_pull;
        logic [DATA_W-1:0] pin_out;
        logic [DATA_W-1:0] pin_oe;
        logic [DATA_W-1:0] ana_pull_en;
        logic [DATA_W-1:0] ana_pull_up;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t cur_ff;
    state_t nxt_state;
    logic [DATA_W-1:0] lvl;

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    pin_sync_if #(.W(DATA_W)) sync_bus ();

    assign sync_bus.raw = pin_i;
    assign lvl = sync_bus.lvl;

    pin_sync #(
        .W(DATA_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .bus(sync_bus)
    );

    // ************************************************************
    // owner priority per pin
    // ************************************************************
    function automatic owner_t pick_owner(input int b);
        owner_t own;
        own = OWN_GPIO;
        case (b)
            BIT_SEG_HI: begin
                if (seg_en_i[3]) begin
                    own = OWN_SEG;
                end
            end
            BIT_SCL: begin
                if (seg_en_i[2]) begin
                    own = OWN_SEG;
                end else if (serial_en_i) begin
                    own = OWN_SERIAL;
                end
            end
            BIT_SDA: begin
                if (seg_en_i[1]) begin
                    own = OWN_SEG;
                end else if (serial_en_i) begin
                    own = OWN_SERIAL;
                end
            end
            BIT_SEG_LO: begin
                if (seg_en_i[0]) begin
                    own = OWN_SEG;
                end
            end
            BIT_T1_HI: begin
                if (t2_oc_en_i[1]) begin
                    own = OWN_TIMER;
                end
            end
            BIT_T1_LO: begin
                if (t2_oc_en_i[0]) begin
                    own = OWN_TIMER;
                end
            end
            BIT_CAN_TX: begin
                if (can_tx_en_i) begin
                    own = OWN_CAN_TX;
                end else if (t1_oc_en_i[1]) begin
                    own = OWN_TIMER;
                end
            end
            default: begin
                if (can_rx_en_i) begin
                    own = OWN_CAN_RX;
                end else if (t1_oc_en_i[0]) begin
                    own = OWN_TIMER;
                end
            end
        endcase
        return own;
    endfunction

    // compare value for whichever timer owns the pin
    function automatic logic timer_val(input int b);
        logic v;
        v = 1'b0;
        case (b)
            BIT_T1_HI: begin
                v = t2_oc_val_i[1];
            end
            BIT_T1_LO: begin
                v = t2_oc_val_i[0];
            end
            BIT_CAN_TX: begin
                v = t1_oc_val_i[1];
            end
            BIT_CAN_RX: begin
                v = t1_oc_val_i[0];
            end
            default: begin
                v = 1'b0;
            end
        endcase
        return v;
    endfunction

    // segment value for bits 7 to 4, index shifted down by four
    function automatic logic seg_val(input int b);
        logic v;
        v = 1'b0;
        if (b >= BIT_SEG_LO) begin
            v = seg_val_i[b - BIT_SEG_LO];
        end
        return v;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        owner_t own;
        own = OWN_GPIO;
        nxt_state = cur_ff;
        // read data stands for one cycle only
        nxt_state.rdata = '0;

        if (wr_i) begin
            if (addr_i == OFS_ANA_PULL) begin
                nxt_state.ana_pull = wdata_i;
            end else if (addr_i == OFS_DATA) begin
                nxt_state.data = wdata_i;
            end else if (addr_i == OFS_DIR) begin
                nxt_state.dir = wdata_i;
            end
        end

        if (rd_i) begin
            if (addr_i == OFS_ANA_PULL) begin
                nxt_state.rdata = cur_ff.ana_pull;
            end else if (addr_i == OFS_DATA) begin
                nxt_state.rdata = (cur_ff.dir & cur_ff.data) | (~cur_ff.dir & lvl);
            end else if (addr_i == OFS_LEVELS) begin
                // synchronised levels whatever owns the pin
                // lets software compare drive and level
                nxt_state.rdata = lvl;
            end else if (addr_i == OFS_DIR) begin
                nxt_state.rdata = cur_ff.dir;
            end else if (addr_i == OFS_RSVD) begin
                nxt_state.rdata = RSVD_VALUE;
            end else begin
                nxt_state.rdata = RSVD_VALUE;
            end
        end

        for (int b = 0; b < DATA_W; b++) begin
            own = pick_owner(b);
            case (own)
                OWN_SEG: begin
                    nxt_state.pin_out[b] = seg_val(b);
                    nxt_state.pin_oe[b] = 1'b1;
                end
                OWN_SERIAL: begin
                    // open drain: only ever drives low
                    nxt_state.pin_out[b] = 1'b0;
                    nxt_state.pin_oe[b] = (b == BIT_SCL) ? scl_low_i : sda_low_i;
                end
                OWN_TIMER: begin
                    nxt_state.pin_out[b] = timer_val(b);
                    nxt_state.pin_oe[b] = 1'b1;
                end
                OWN_CAN_TX: begin
                    nxt_state.pin_out[b] = can_tx_i;
                    nxt_state.pin_oe[b] = 1'b1;
                end
                OWN_CAN_RX: begin
                    // receiver listens, driver released
                    nxt_state.pin_out[b] = 1'b0;
                    nxt_state.pin_oe[b] = 1'b0;
                end
                default: begin
                    // capture pins rely on software keeping input here
                    nxt_state.pin_out[b] = cur_ff.data[b];
                    nxt_state.pin_oe[b] = cur_ff.dir[b];
                end
            endcase
        end

        nxt_state.ana_pull_en = cur_ff.ana_pull & ~ana_dir_i;
        nxt_state.ana_pull_up = ana_pol_i;
    end

    // ************************************************************
    // registers
    // ************************************************************
    // pins released and pulls off while reset is held
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff.data <= DATA_RST;
            cur_ff.dir <= DIR_RST;
            cur_ff.ana_pull <= ANA_PULL_RST;
            cur_ff.pin_out <= '0;
            cur_ff.pin_oe <= '0;
            cur_ff.ana_pull_en <= '0;
            cur_ff.ana_pull_up <= '0;
            cur_ff.rdata <= '0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // level path delay bounds read settling
    // limitation: a pin change needs four edges to reach the level
    // register, more than two, because every pin input passes the
    // three-stage agreement filter
    assign pin_level_o = lvl;
    assign rdata_o = cur_ff.rdata;
    assign pin_o = cur_ff.pin_out;
    assign pin_oe_o = cur_ff.pin_oe;
    assign ana_pull_en_o = cur_ff.ana_pull_en;
    assign ana_pull_up_o = cur_ff.ana_pull_up;

endmodule

`default_nettype wire

// ==== sim/port_r_gpio_assertions.sv ====
// Purpose: port checks for port_r_gpio
// Assumes: one clock domain, asynchronous reset
// Notes: pin and pull outputs lag their causes by one edge
`timescale 1ns/1ps
`default_nettype none

module port_r_gpio_assertions (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [port_r_pkg::ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [port_r_pkg::DATA_W-1:0] rdata_o,
    // pins
    input wire logic [port_r_pkg::DATA_W-1:0] pin_o,
    input wire logic [port_r_pkg::DATA_W-1:0] pin_oe_o,
    input wire logic [port_r_pkg::DATA_W-1:0] pin_level_o,
    // peripherals
    input wire logic [3:0] seg_en_i,
    input wire logic [3:0] seg_val_i,
    input wire logic serial_en_i,
    input wire logic scl_low_i,
    input wire logic [1:0] t2_oc_en_i,
    input wire logic [1:0] t2_oc_val_i,
    input wire logic can_tx_en_i,
    input wire logic can_tx_i,
    input wire logic can_rx_en_i,
    // analog port
    input wire logic [port_r_pkg::DATA_W-1:0] ana_dir_i,
    input wire logic [port_r_pkg::DATA_W-1:0] ana_pol_i,
    input wire logic [port_r_pkg::DATA_W-1:0] ana_pull_en_o,
    input wire logic [port_r_pkg::DATA_W-1:0] ana_pull_up_o
);
    import port_r_pkg::*;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_rsvd_reads_zero: assert property (rd_i && addr_i == OFS_RSVD
        |=> rdata_o == RSVD_VALUE)
        else $error("reserved read not zero");
    a_levels_read_back: assert property (rd_i && addr_i == OFS_LEVELS
        |=> rdata_o == $past(pin_level_o))
        else $error("level read differs");
    a_seg_owns_top: assert property (seg_en_i[3]
        |=> pin_oe_o[7] && pin_o[7] == $past(seg_val_i[3]))
        else $error("segment lost pin 7");
    a_serial_owns_clk: assert property (serial_en_i && !seg_en_i[2]
        |=> !pin_o[6] && pin_oe_o[6] == $past(scl_low_i))
        else $error("serial lost pin 6");
    a_timer_owns_hi: assert property (t2_oc_en_i[1]
        |=> pin_oe_o[3] && pin_o[3] == $past(t2_oc_val_i[1]))
        else $error("timer lost pin 3");
    a_can_tx_owns: assert property (can_tx_en_i
        |=> pin_oe_o[1] && pin_o[1] == $past(can_tx_i))
        else $error("transmit lost pin 1");
    a_can_rx_owns: assert property (can_rx_en_i |=> !pin_oe_o[0])
        else $error("receive pin driven");
    a_pull_output_off: assert property (1'h1
        |=> (ana_pull_en_o & $past(ana_dir_i)) == 8'h00)
        else $error("pull on at output");
    a_pull_polarity_copy: assert property (1'h1 |=> ana_pull_up_o == $past(ana_pol_i))
        else $error("pull polarity wrong");
endmodule

bind port_r_gpio port_r_gpio_assertions port_r_gpio_assertions_inst (.sys_clk_i, .rst_i,
    .addr_i, .rd_i, .rdata_o, .pin_o, .pin_oe_o, .pin_level_o, .seg_en_i, .seg_val_i,
    .serial_en_i, .scl_low_i, .t2_oc_en_i, .t2_oc_val_i, .can_tx_en_i, .can_tx_i,
    .can_rx_en_i, .ana_dir_i, .ana_pol_i, .ana_pull_en_o, .ana_pull_up_o);
`default_nettype wire

// ==== sim/port_r_pins_model.sv ====
// Purpose: port R pin wires with outside level and fault injection
// Assumes: an undriven pin sits at the level the bench supplies
// Notes: a short flips the wire whoever drives it
`timescale 1ns/1ps
`default_nettype none

module port_r_pins_model (
    // from the port
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    // bench controls
    input wire logic [7:0] ext_i,
    input wire logic [7:0] short_i,
    // to the port
    output logic [7:0] pin_i
);
    assign pin_i = ((pin_oe_o & pin_o) | (~pin_oe_o & ext_i)) ^ short_i;
endmodule
`default_nettype wire

// ==== sim/port_r_gpio_test.sv ====
// Purpose: self-checking bench for port_r_gpio
// Assumes: one-cycle strobes, read data one cycle later
// Notes: level sync takes four edges, so the bench waits six
`timescale 1ns/1ps
`default_nettype none

module port_r_gpio_test;
    import port_r_pkg::*;
    logic sys_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [7:0] rdata_o, pin_i, pin_o, pin_oe_o, pin_level_o, ana_pull_en_o, ana_pull_up_o;
    logic [3:0] seg_en_i = 4'h0;
    logic [3:0] seg_val_i = 4'h0;
    logic serial_en_i = 1'h0, scl_low_i = 1'h0, sda_low_i = 1'h0;
    logic [1:0] t2_oc_en_i = 2'h0, t2_oc_val_i = 2'h0, t1_oc_en_i = 2'h0, t1_oc_val_i = 2'h0;
    logic can_tx_en_i = 1'h0, can_tx_i = 1'h0, can_rx_en_i = 1'h0;
    logic [7:0] ana_dir_i = 8'h00, ana_pol_i = 8'h00, ext = 8'h00, sht = 8'h00;
    logic [7:0] dv, dd, rv, eo, eoe;
    int error_cnt = 0, comparisons = 0, cyc = 0;

    port_r_gpio port_r_gpio_inst (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pin_level_o, .seg_en_i, .seg_val_i,
        .serial_en_i, .scl_low_i, .sda_low_i, .t2_oc_en_i, .t2_oc_val_i, .t1_oc_en_i,
        .t1_oc_val_i, .can_tx_en_i, .can_tx_i, .can_rx_en_i, .ana_dir_i, .ana_pol_i,
        .ana_pull_en_o, .ana_pull_up_o);
    port_r_pins_model port_r_pins_model_inst (.pin_o, .pin_oe_o, .ext_i(ext),
        .short_i(sht), .pin_i);

    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    // ****************************************
    // bus tasks and expectations
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'h0;
        #1 rv = rdata_o;
        chk(rv, e);
    endtask
    task automatic results();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // owner priority: segment, serial, second timer, can, first timer, then general use
    function automatic logic [15:0] drv(input logic [7:0] d, input logic [7:0] v);
        logic [7:0] oe, o;
        oe[7] = seg_en_i[3] | d[7];
        o[7] = seg_en_i[3] ? seg_val_i[3] : v[7];
        oe[6] = seg_en_i[2] ? 1'h1 : serial_en_i ? scl_low_i : d[6];
        o[6] = seg_en_i[2] ? seg_val_i[2] : serial_en_i ? 1'h0 : v[6];
        oe[5] = seg_en_i[1] ? 1'h1 : serial_en_i ? sda_low_i : d[5];
        o[5] = seg_en_i[1] ? seg_val_i[1] : serial_en_i ? 1'h0 : v[5];
        oe[4] = seg_en_i[0] | d[4];
        o[4] = seg_en_i[0] ? seg_val_i[0] : v[4];
        oe[3:2] = t2_oc_en_i | d[3:2];
        o[3:2] = (t2_oc_en_i & t2_oc_val_i) | (~t2_oc_en_i & v[3:2]);
        oe[1] = can_tx_en_i | t1_oc_en_i[1] | d[1];
        o[1] = can_tx_en_i ? can_tx_i : t1_oc_en_i[1] ? t1_oc_val_i[1] : v[1];
        oe[0] = can_rx_en_i ? 1'h0 : t1_oc_en_i[0] | d[0];
        o[0] = t1_oc_en_i[0] ? t1_oc_val_i[0] : v[0];
        return {oe, o};
    endfunction
    function automatic logic [7:0] lvl();
        return ((eoe & eo) | (~eoe & ext)) ^ sht;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hCFE7));
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        rdchk(OFS_ANA_PULL, ANA_PULL_RST);
        rdchk(OFS_DIR, DIR_RST);
        rdchk(4'hA, 8'h00);
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_i);
            dv = 8'($urandom);
            ana_dir_i <= (i == 0) ? 8'h00 : 8'($urandom);
            ana_pol_i <= 8'($urandom);
            wr(OFS_ANA_PULL, dv);
            rdchk(OFS_ANA_PULL, dv);
            repeat (2) @(posedge sys_clk_i);
            #1 chk(ana_pull_en_o, dv & ~ana_dir_i);
            chk(ana_pull_up_o, ana_pol_i);
        end
        // no pin is used for capture, so direction is free
        for (int i = 0; i < 24; i++) begin
            @(posedge sys_clk_i);
            dv = 8'($urandom);
            dd = (i == 0) ? 8'hFF : 8'($urandom);
            ext <= 8'($urandom);
            sht <= (i < 3) ? 8'h00 : 8'($urandom);
            {seg_en_i, seg_val_i, t2_oc_en_i, t2_oc_val_i, t1_oc_en_i, t1_oc_val_i}
                <= (i < 4) ? 16'h0000 : 16'($urandom);
            {serial_en_i, scl_low_i, sda_low_i, can_tx_en_i, can_tx_i, can_rx_en_i}
                <= (i < 4) ? 6'h00 : 6'($urandom);
            wr(OFS_DATA, dv);
            wr(OFS_DIR, dd);
            wr(OFS_LEVELS, ~dv);
            wr(OFS_RSVD, dv);
            repeat (6) @(posedge sys_clk_i);
            #1 {eoe, eo} = drv(dd, dv);
            chk(pin_oe_o, eoe);
            chk(pin_o & eoe, eo & eoe);
            rdchk(OFS_DATA, (dv & dd) | (lvl() & ~dd));
            rdchk(OFS_LEVELS, lvl());
            rdchk(OFS_RSVD, RSVD_VALUE);
        end
        @(posedge sys_clk_i);
        sht <= sht ^ 8'hFF;
        @(posedge sys_clk_i);
        sht <= sht ^ 8'hFF;
        // a one-cycle glitch must never reach the level output
        repeat (6) begin
            @(posedge sys_clk_i);
            #1 chk(pin_level_o, lvl());
        end
        results();
    end
endmodule
`default_nettype wire
